// file: design/urx_defs.svh
`ifndef URX_DEFS_SVH
`define URX_DEFS_SVH
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define URX_ADDR_CTRL_A 3'h0
`define URX_ADDR_CTRL_B 3'h1
`define URX_ADDR_CTRL_C 3'h2
`define URX_ADDR_STAT_A 3'h3
`define URX_ADDR_DATA 3'h4
`define URX_ADDR_HALT 3'h5
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define URX_A_NINE 4
`define URX_A_WAKE 3
`define URX_A_QSEL 2
`define URX_A_PEN 1
`define URX_A_PODD 0
`define URX_B_RXIE 5
`define URX_B_LINE_QUIET_IRQ_EN 4
`define URX_B_RE 2
`define URX_B_STBY 1
`define URX_C_OVERRUN_IRQ_EN 3
`define URX_C_NOISE_IRQ_EN 2
`define URX_C_FRAMING_IRQ_EN 1
`define URX_C_PARITY_IRQ_EN 0
`define URX_S_FULL 5
`define URX_S_IDLE 4
`define URX_S_OR 3
`define URX_S_NF 2
`define URX_S_FE 1
`define URX_S_PE 0
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define URX_TICKS_PER_BIT 5'h10
`define URX_SAMP_A 4'h3
`define URX_SAMP_B 4'h5
`define URX_SAMP_C 4'h7
`define URX_MID_A 4'h8
`define URX_MID_B 4'h9
`define URX_MID_C 4'hA
`define URX_LAST_TICK 4'hF
`define URX_BITS_8 4'h9
`define URX_BITS_9 4'hA
`define URX_IDLE_8 4'hA
`define URX_IDLE_9 4'hB
`define URX_REG_RESET 8'h00
`endif

// file: design/urx_pkg.sv
package urx_pkg;
  typedef enum logic [1:0] {URX_HUNT, URX_START, URX_DATA, URX_STOP} urx_state_t;
  typedef logic [7:0] urx_byte_t;
  typedef logic [2:0] urx_addr_t;
endpackage : urx_pkg

// file: design/urx_rx_status.sv
`timescale 1ns/10ps
`include "urx_defs.svh"
// How it works
// - Stop bit sampled as zero sets the framing error flag.
// - Break character, having no stop bit, also sets framing error.
// - Framing error sets in the same cycle as receiver full.
// - One stray stop sample flags noise; two or more flag framing error.
// - Valid falling edges inside a character resync the tick counter.
// - Stop bit sampled at ticks 8, 9, 10 of its 16-tick bit.
// - Standby request suppresses receiver-full and idle interrupt requests; error requests stay unmasked.
// - Address-mark wakeup: MSB one clears standby and sets receiver full.
// - Idle wakeup clears standby; waking idle sets neither idle nor full.
// - Select whether idle counting starts after start or stop bit.
// - Character into data register sets full; interrupt when enabled.
// - Idle flag after 10 or 11 ones; interrupt when enabled.
// - Overrun keeps old character, drops new, sets overrun flag.
// - Noise in start, data or stop bit sets noise flag.
// - Enabled framing error raises error interrupt.
// - Parity failure sets parity error flag; enabled raises interrupt.
// - Wait mode keeps receiver running; enabled requests end wait.
// - Stop mode freezes block, keeps registers, drops partial character.
// - Debug-halt clear allowed: software clears take effect and persist.
// - Halt clears blocked; two-step clear completes after halt.
// - Tick runs at sixteen times baud; bits sampled against it.
// - Start confirmed by ticks 3, 5, 7; two ones reject, one flags noise.
// - Stop majority zero is framing error; disagreement is noise.
module urx_rx_status (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Oversample tick and receive pin
  input wire logic os_tick,
  input wire logic rxd_pin,
  // Low-power states
  input wire logic stop_mode,
  input wire logic dbg_halt,
  // Register port
  input wire urx_pkg::urx_addr_t addr,
  input wire urx_pkg::urx_byte_t wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output urx_pkg::urx_byte_t rdata,
  // Requests
  output logic rx_irq,
  output logic err_irq,
  output logic wake_req
);
  import urx_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : maj3

  function automatic logic mixed3(input logic [2:0] s);
    mixed3 = (s != 3'h0) && (s != 3'h7);
  endfunction : mixed3

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  logic [2:0] sync_reg;
  logic rx_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= 3'h7;
    end else begin
      sync_reg <= {sync_reg[1:0], rxd_pin};
    end
  end
  // Pin counts only once stages two and three agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_reg <= 1'b1;
    end else if (sync_reg[1] == sync_reg[2]) begin
      rx_reg <= sync_reg[2];
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  urx_byte_t ctrl_a_reg, ctrl_b_reg, ctrl_c_reg, halt_reg;
  logic nine_bit, wake_sel, quiet_count_start_sel, par_en, par_odd;
  logic rx_full_irq_en, line_quiet_irq_en, rx_en;
  logic overrun_irq_en, noise_irq_en, framing_irq_en, parity_irq_en, dbg_halt_clear_allow;
  assign nine_bit = ctrl_a_reg[`URX_A_NINE];
  assign wake_sel = ctrl_a_reg[`URX_A_WAKE];
  assign quiet_count_start_sel = ctrl_a_reg[`URX_A_QSEL];
  assign par_en = ctrl_a_reg[`URX_A_PEN];
  assign par_odd = ctrl_a_reg[`URX_A_PODD];
  assign rx_full_irq_en = ctrl_b_reg[`URX_B_RXIE];
  assign line_quiet_irq_en = ctrl_b_reg[`URX_B_LINE_QUIET_IRQ_EN];
  assign rx_en = ctrl_b_reg[`URX_B_RE];
  assign overrun_irq_en = ctrl_c_reg[`URX_C_OVERRUN_IRQ_EN];
  assign noise_irq_en = ctrl_c_reg[`URX_C_NOISE_IRQ_EN];
  assign framing_irq_en = ctrl_c_reg[`URX_C_FRAMING_IRQ_EN];
  assign parity_irq_en = ctrl_c_reg[`URX_C_PARITY_IRQ_EN];
  assign dbg_halt_clear_allow = halt_reg[0];

  logic standby_request;
  logic wake_now;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_a_reg <= `URX_REG_RESET;
      ctrl_c_reg <= `URX_REG_RESET;
      halt_reg <= `URX_REG_RESET;
    end else if (wr_stb) begin
      if (addr == `URX_ADDR_CTRL_A) begin
        ctrl_a_reg <= {3'h0, wdata[4:0]};
      end else if (addr == `URX_ADDR_CTRL_C) begin
        ctrl_c_reg <= {4'h0, wdata[3:0]};
      end else if (addr == `URX_ADDR_HALT) begin
        halt_reg <= {7'h00, wdata[0]};
      end
    end
  end
  // Hardware wake wins over a same-cycle software write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_b_reg <= `URX_REG_RESET;
    end else if (wake_now) begin
      ctrl_b_reg[`URX_B_STBY] <= 1'b0;
    end else if (wr_stb && addr == `URX_ADDR_CTRL_B) begin
      ctrl_b_reg <= {2'h0, wdata[5:4], 1'b0, wdata[2:1], 1'b0};
    end
  end
  assign standby_request = ctrl_b_reg[`URX_B_STBY];

  // ------------------------------------------------------------
  // Receive engine
  // ------------------------------------------------------------
  urx_state_t state_reg;
  logic [3:0] tick_reg, bit_reg, ones_reg;
  logic [2:0] samp_reg;
  logic [8:0] shift_reg;
  logic prev_bit_reg, any_noise_reg;
  logic run, tick, at_end, last_data;
  logic [2:0] samp_full;
  logic bit_val;
  // Stop mode freezes the tick and sends the engine back to hunt; enable gates fresh starts
  assign run = !stop_mode;
  assign tick = os_tick && run;
  assign at_end = tick && tick_reg == `URX_LAST_TICK;
  assign samp_full = {samp_reg[1:0], rx_reg};
  assign bit_val = maj3(samp_full);
  assign last_data = bit_reg == (nine_bit ? `URX_BITS_9 : `URX_BITS_8) - 4'h1;

  logic char_done, char_stop_bad, char_noise;
  urx_byte_t char_data;
  logic char_msb, char_par_bad;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= URX_HUNT;
      tick_reg <= 4'h0;
      bit_reg <= 4'h0;
      samp_reg <= 3'h0;
      shift_reg <= 9'h000;
      prev_bit_reg <= 1'b1;
      any_noise_reg <= 1'b0;
    end else if (stop_mode) begin
      state_reg <= URX_HUNT;
    end else if (tick) begin
      tick_reg <= tick_reg + 4'h1;
      if (tick_reg == `URX_SAMP_A || tick_reg == `URX_SAMP_B || tick_reg == `URX_SAMP_C
          || tick_reg == `URX_MID_A || tick_reg == `URX_MID_B || tick_reg == `URX_MID_C) begin
        samp_reg <= samp_full;
      end
      case (state_reg)
        // Count runs free so idle bits are timed; start needs a one-to-zero edge
        URX_HUNT: begin
          any_noise_reg <= 1'b0;
          prev_bit_reg <= rx_reg;
          if (prev_bit_reg && !rx_reg && rx_en) begin
            state_reg <= URX_START;
            tick_reg <= 4'h1;
          end
        end
        URX_START: begin
          if (tick_reg == `URX_SAMP_C) begin
            if (maj3(samp_full)) begin
              state_reg <= URX_HUNT;
            end else begin
              any_noise_reg <= mixed3(samp_full);
            end
          end else if (tick_reg == `URX_MID_C) begin
            if (samp_full != 3'h0) begin
              any_noise_reg <= 1'b1;
            end
          end else if (tick_reg == `URX_LAST_TICK) begin
            state_reg <= URX_DATA;
            bit_reg <= 4'h1;
            prev_bit_reg <= 1'b0;
          end
        end
        URX_DATA: begin
          if (tick_reg == `URX_MID_C) begin
            if (mixed3(samp_full)) begin
              any_noise_reg <= 1'b1;
            end
            shift_reg <= {bit_val, shift_reg[8:1]};
            prev_bit_reg <= bit_val;
          end else if (tick_reg == `URX_LAST_TICK) begin
            bit_reg <= bit_reg + 4'h1;
            if (last_data) begin
              state_reg <= URX_STOP;
            end
          end else if (prev_bit_reg && !rx_reg && tick_reg > `URX_MID_C) begin
            tick_reg <= 4'h1;
            bit_reg <= bit_reg + 4'h1;
            if (last_data) begin
              state_reg <= URX_STOP;
            end
          end
        end
        URX_STOP: begin
          if (tick_reg == `URX_MID_C) begin
            state_reg <= URX_HUNT;
            // A break leaves the line low; no new start until it rises
            prev_bit_reg <= bit_val;
          end
        end
        default: state_reg <= URX_HUNT;
      endcase
    end
  end

  // Stop judged at tick 10 (bit 9 or 10: 154 or 170 ticks)
  assign char_done = tick && state_reg == URX_STOP && tick_reg == `URX_MID_C;
  assign char_stop_bad = !maj3(samp_full);
  assign char_noise = any_noise_reg || mixed3(samp_full);
  assign char_data = nine_bit ? shift_reg[7:0] : shift_reg[8:1];
  assign char_msb = nine_bit ? shift_reg[8] : shift_reg[8];
  assign char_par_bad = par_en && ((nine_bit ? ^shift_reg : ^shift_reg[8:1]) != par_odd);

  // ------------------------------------------------------------
  // Idle detection
  // ------------------------------------------------------------
  logic idle_hit, idle_armed_reg;
  // Counts whole one-bit times; restart point chosen by select
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ones_reg <= 4'h0;
      idle_armed_reg <= 1'b0;
    end else if (tick && tick_reg == `URX_MID_C) begin
      if (state_reg == URX_START) begin
        ones_reg <= 4'h0;
        idle_armed_reg <= 1'b1;
      end else if (state_reg == URX_DATA && quiet_count_start_sel) begin
        ones_reg <= 4'h0;
      end else if (!bit_val) begin
        ones_reg <= 4'h0;
      end else if (!idle_hit) begin
        ones_reg <= ones_reg + 4'h1;
      end else begin
        idle_armed_reg <= 1'b0;
      end
    end else if (idle_hit && at_end) begin
      idle_armed_reg <= 1'b0;
    end
  end
  // Armed once per line-quiet period so the flag fires once
  logic idle_event;
  assign idle_hit = ones_reg >= (nine_bit ? `URX_IDLE_9 : `URX_IDLE_8);
  assign idle_event = idle_hit && idle_armed_reg && at_end;

  // ------------------------------------------------------------
  // Wakeup
  // ------------------------------------------------------------
  logic addr_wake, idle_wake;
  assign addr_wake = standby_request && wake_sel && char_done && char_msb;
  assign idle_wake = standby_request && !wake_sel && idle_event;
  assign wake_now = addr_wake || idle_wake;

  // ------------------------------------------------------------
  // Status flags and data
  // ------------------------------------------------------------
  urx_byte_t data_reg;
  logic full_reg, idle_reg, or_reg, nf_reg, fe_reg, pe_reg, armed_reg;
  logic accept, sw_ok, stat_rd, data_rd, clr_step;
  // Characters in standby are dropped unless they wake the block
  assign accept = char_done && (!standby_request || addr_wake);
  assign sw_ok = !dbg_halt || dbg_halt_clear_allow;
  assign stat_rd = rd_stb && addr == `URX_ADDR_STAT_A;
  assign data_rd = rd_stb && addr == `URX_ADDR_DATA;
  assign clr_step = data_rd && armed_reg && sw_ok;

  // First step of the two-step clear survives a halt
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_reg <= 1'b0;
    end else if (stat_rd && sw_ok) begin
      armed_reg <= 1'b1;
    end else if (clr_step) begin
      armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= `URX_REG_RESET;
    end else if (accept && !full_reg) begin
      data_reg <= char_data;
    end
  end

  // Set wins over clear on every flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      full_reg <= 1'b0;
      or_reg <= 1'b0;
      nf_reg <= 1'b0;
      fe_reg <= 1'b0;
      pe_reg <= 1'b0;
    end else begin
      if (accept) begin
        full_reg <= 1'b1;
        or_reg <= or_reg | full_reg;
        nf_reg <= nf_reg | char_noise;
        fe_reg <= fe_reg | char_stop_bad;
        pe_reg <= pe_reg | (!full_reg & char_par_bad);
      end else if (clr_step) begin
        full_reg <= 1'b0;
        or_reg <= 1'b0;
        nf_reg <= 1'b0;
        fe_reg <= 1'b0;
        pe_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_reg <= 1'b0;
    end else if (idle_event && !standby_request) begin
      idle_reg <= 1'b1;
    end else if (clr_step) begin
      idle_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  urx_byte_t status;
  assign status = {2'h0, full_reg, idle_reg, or_reg, nf_reg, fe_reg, pe_reg};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= `URX_REG_RESET;
    end else if (!rd_stb) begin
      rdata <= `URX_REG_RESET;
    end else if (addr == `URX_ADDR_CTRL_A) begin
      rdata <= ctrl_a_reg;
    end else if (addr == `URX_ADDR_CTRL_B) begin
      rdata <= ctrl_b_reg;
    end else if (addr == `URX_ADDR_CTRL_C) begin
      rdata <= ctrl_c_reg;
    end else if (addr == `URX_ADDR_STAT_A) begin
      rdata <= status;
    end else if (addr == `URX_ADDR_DATA) begin
      rdata <= data_reg;
    end else if (addr == `URX_ADDR_HALT) begin
      rdata <= halt_reg;
    end else begin
      rdata <= `URX_REG_RESET;
    end
  end

  // ------------------------------------------------------------
  // Requests
  // ------------------------------------------------------------
  // Standby masks receiver requests; stop mode masks wake
  assign rx_irq = !standby_request && ((full_reg && rx_full_irq_en) || (idle_reg && line_quiet_irq_en));
  assign err_irq = (or_reg && overrun_irq_en) || (nf_reg && noise_irq_en)
                   || (fe_reg && framing_irq_en) || (pe_reg && parity_irq_en);
  assign wake_req = (rx_irq || err_irq) && !stop_mode;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_char_end;
    char_done && accept;
  endsequence

  chk_fe_with_full: assert property (@(posedge clk) disable iff (!arst_n)
    (s_char_end and char_stop_bad) |=> fe_reg && full_reg)
    else $error("framing error not set with receiver full");
  chk_overrun_keeps_data: assert property (@(posedge clk) disable iff (!arst_n)
    (s_char_end and full_reg) |=> or_reg && data_reg == $past(data_reg))
    else $error("overrun lost old character");
  chk_noise_set: assert property (@(posedge clk) disable iff (!arst_n)
    (s_char_end and char_noise) |=> nf_reg)
    else $error("noise flag missed");
  chk_standby_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    standby_request |-> !rx_irq)
    else $error("receiver request in standby");
  chk_addr_wake: assert property (@(posedge clk) disable iff (!arst_n)
    addr_wake |=> !standby_request && full_reg)
    else $error("address mark wake failed");
  chk_idle_wake_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    idle_wake && !idle_reg && !full_reg |=> !idle_reg && !full_reg && !standby_request)
    else $error("waking idle set a flag");
  chk_err_irq_or: assert property (@(posedge clk) disable iff (!arst_n)
    err_irq == ((or_reg & overrun_irq_en) | (nf_reg & noise_irq_en) | (fe_reg & framing_irq_en)
                | (pe_reg & parity_irq_en)))
    else $error("error request mismatch");
  chk_halt_protect: assert property (@(posedge clk) disable iff (!arst_n)
    dbg_halt && !dbg_halt_clear_allow && !accept && full_reg |=> full_reg)
    else $error("flag cleared during halt");
  chk_stop_freeze: assert property (@(posedge clk) disable iff (!arst_n)
    stop_mode |-> !wake_req ##1 ($stable(data_reg) && state_reg == URX_HUNT))
    else $error("activity in stop mode");
endmodule : urx_rx_status

// file: testbench/urx_rx_status_bench.sv
`timescale 1ns/10ps
`include "urx_defs.svh"
module urx_rx_status_bench;
  import urx_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int TDIV = 4;
  localparam urx_addr_t CA = `URX_ADDR_CTRL_A;
  localparam urx_addr_t CB = `URX_ADDR_CTRL_B;
  localparam urx_addr_t CC = `URX_ADDR_CTRL_C;
  localparam urx_addr_t ST = `URX_ADDR_STAT_A;
  localparam urx_addr_t DT = `URX_ADDR_DATA;
  localparam urx_addr_t HT = `URX_ADDR_HALT;
  typedef struct packed {
    urx_byte_t ca;
    urx_byte_t cc;
    logic [8:0] ch;
    logic stp;
    urx_byte_t est;
    urx_byte_t edat;
    logic eerr;
  } urx_row_t;
  localparam urx_row_t rows [6] = '{
    '{8'h00, 8'h0F, 9'h05A, 1'b1, 8'h20, 8'h5A, 1'b0},
    '{8'h00, 8'h02, 9'h000, 1'b0, 8'h22, 8'h00, 1'b1},
    '{8'h02, 8'h00, 9'h035, 1'b1, 8'h20, 8'h35, 1'b0},
    '{8'h03, 8'h01, 9'h035, 1'b1, 8'h21, 8'h35, 1'b1},
    '{8'h10, 8'h00, 9'h1A5, 1'b1, 8'h20, 8'hA5, 1'b0},
    '{8'h13, 8'h00, 9'h007, 1'b1, 8'h20, 8'h07, 1'b0}};
  logic clk = 1'b0;
  logic arst_n;
  logic os_tick = 1'b0;
  wire logic rxd_pin;
  logic stop_mode;
  logic dbg_halt;
  urx_addr_t addr;
  urx_byte_t wdata;
  logic wr_stb;
  logic rd_stb;
  urx_byte_t rdata;
  logic rx_irq;
  logic err_irq;
  logic wake_req;
  urx_byte_t rv;
  int tick_cnt = 0;
  int err_total;
  int compares;
  urx_rx_status u_urx_rx_status (.clk(clk), .arst_n(arst_n), .os_tick(os_tick), .rxd_pin(rxd_pin),
    .stop_mode(stop_mode), .dbg_halt(dbg_halt), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .rx_irq(rx_irq), .err_irq(err_irq), .wake_req(wake_req));
  urx_tx_model #(.TDIV(TDIV)) u_urx_tx_model (.clk(clk), .rxd_line(rxd_pin));
  // ------------------------------------------------------------
  // Clock, tick and tasks
  // ------------------------------------------------------------
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    tick_cnt <= (tick_cnt + 1) % TDIV;
    os_tick <= (tick_cnt == 0);
  end
  task automatic check(input string name, input urx_byte_t seen, input urx_byte_t exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic chk1(input string name, input logic seen, input logic exp);
    check(name, {7'h00, seen}, {7'h00, exp});
  endtask : chk1
  task automatic wr(input urx_addr_t a, input urx_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input urx_addr_t a, output urx_byte_t d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic rdchk(input urx_addr_t a, input urx_byte_t exp, input string name);
    urx_byte_t d;
    rd(a, d);
    check(name, d, exp);
  endtask : rdchk
  task automatic halt(input logic v);
    @(posedge clk);
    dbg_halt <= v;
  endtask : halt
  task automatic test_done;
    $display("Checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    test_done();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    stop_mode = 1'b0;
    dbg_halt = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rdchk(urx_addr_t'(a), 8'h00, "reset value");
    end
    foreach (rows[i]) begin
      wr(CA, rows[i].ca);
      wr(CC, rows[i].cc);
      wr(CB, 8'h24);
      u_urx_tx_model.send_char(rows[i].ch, rows[i].ca[4], rows[i].stp);
      rdchk(ST, rows[i].est, "status");
      chk1("rx_irq", rx_irq, 1'b1);
      chk1("err_irq", err_irq, rows[i].eerr);
      chk1("wake_req", wake_req, 1'b1);
      rdchk(DT, rows[i].edat, "data");
      rdchk(ST, 8'h00, "cleared status");
    end
    // Two characters with no read in between
    wr(CA, 8'h00);
    wr(CC, 8'h08);
    u_urx_tx_model.send_char(9'h011, 1'b0, 1'b1);
    u_urx_tx_model.send_char(9'h022, 1'b0, 1'b1);
    rdchk(ST, 8'h28, "overrun status");
    chk1("overrun irq", err_irq, 1'b1);
    rdchk(DT, 8'h11, "kept data");
    // One stray sample per data bit: data intact, noise flagged
    wr(CC, 8'h04);
    u_urx_tx_model.send_noisy(8'h5A);
    rdchk(ST, 8'h24, "noise status");
    chk1("noise irq", err_irq, 1'b1);
    rdchk(DT, 8'h5A, "noisy data");
    // Trailing ones count toward idle only when counting starts after start
    wr(CB, 8'h34);
    for (int q = 0; q < 2; q++) begin
      wr(CA, q ? 8'h04 : 8'h00);
      u_urx_tx_model.send_char(9'h0F0, 1'b0, 1'b1);
      u_urx_tx_model.hold_idle(7);
      rdchk(ST, q ? 8'h20 : 8'h30, "idle select");
      chk1("quiet irq", rx_irq, 1'b1);
      rd(DT, rv);
      u_urx_tx_model.hold_idle(5);
      rd(ST, rv);
      rd(DT, rv);
    end
    // Idle wakeup, armed right after a character to avoid an early wake
    wr(CA, 8'h00);
    u_urx_tx_model.send_char(9'h05A, 1'b0, 1'b1);
    rd(ST, rv);
    rd(DT, rv);
    wr(CB, 8'h26);
    u_urx_tx_model.hold_idle(12);
    rdchk(CB, 8'h24, "idle wake");
    rdchk(ST, 8'h00, "waking idle");
    // Address mark wakeup
    wr(CA, 8'h08);
    wr(CB, 8'h26);
    u_urx_tx_model.send_char(9'h001, 1'b0, 1'b1);
    rdchk(ST, 8'h00, "standby drop");
    chk1("standby irq", rx_irq, 1'b0);
    u_urx_tx_model.send_char(9'h081, 1'b0, 1'b1);
    rdchk(CB, 8'h24, "mark wake");
    rdchk(ST, 8'h20, "mark full");
    // Halt with clears blocked, then a clear armed before the halt
    wr(HT, 8'h00);
    halt(1'b1);
    rd(ST, rv);
    rd(DT, rv);
    halt(1'b0);
    rdchk(ST, 8'h20, "halt protect");
    halt(1'b1);
    halt(1'b0);
    rdchk(DT, 8'h81, "mark data");
    rdchk(ST, 8'h00, "two step");
    wr(HT, 8'h01);
    u_urx_tx_model.send_char(9'h033, 1'b0, 1'b1);
    halt(1'b1);
    rd(ST, rv);
    rd(DT, rv);
    halt(1'b0);
    rdchk(ST, 8'h00, "halt clear");
    // Stop mode drops traffic and keeps state
    @(posedge clk);
    stop_mode <= 1'b1;
    u_urx_tx_model.send_char(9'h044, 1'b0, 1'b1);
    stop_mode <= 1'b0;
    rdchk(ST, 8'h00, "stop drop");
    rdchk(CB, 8'h24, "stop keep");
    u_urx_tx_model.send_char(9'h044, 1'b0, 1'b1);
    stop_mode <= 1'b1;
    repeat (2) @(posedge clk);
    chk1("stop wake", wake_req, 1'b0);
    stop_mode <= 1'b0;
    rdchk(ST, 8'h20, "after stop");
    test_done();
  end
endmodule : urx_rx_status_bench

// file: testbench/urx_tx_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Remote serial transmitter
// ------------------------------------------------------------
module urx_tx_model #(
  parameter int TDIV = 4
) (
  // Clock
  input wire logic clk,
  // Serial line
  output logic rxd_line
);
  // Line rests at mark level between characters
  initial begin
    rxd_line = 1'b1;
  end
  task automatic send_bit(input logic b);
    rxd_line <= b;
    repeat (16 * TDIV) @(posedge clk);
  endtask : send_bit
  // Stop level of zero gives a break when the data are all zero
  task automatic send_char(input logic [8:0] ch, input logic nine, input logic stp);
    send_bit(1'b0);
    for (int i = 0; i < 9; i++) begin
      if (i < 8 || nine) begin
        send_bit(ch[i]);
      end
    end
    send_bit(stp);
    // Only a zero stop level needs the line put back; avoids a double drive before the next start
    if (!stp) begin
      rxd_line <= 1'b1;
    end
  endtask : send_char
  // Each data bit carries a one-tick inverted pulse near its middle
  task automatic send_noisy(input logic [7:0] ch);
    send_bit(1'b0);
    for (int i = 0; i < 8; i++) begin
      rxd_line <= ch[i];
      repeat (9 * TDIV) @(posedge clk);
      rxd_line <= ~ch[i];
      repeat (TDIV) @(posedge clk);
      rxd_line <= ch[i];
      repeat (6 * TDIV) @(posedge clk);
    end
    send_bit(1'b1);
  endtask : send_noisy
  task automatic hold_idle(input int nbits);
    repeat (nbits * 16 * TDIV) @(posedge clk);
  endtask : hold_idle
endmodule : urx_tx_model
